// ==== common/ssq_pkg.sv ====
// Constants and types for the SYSREF sync and start-up sequencer
// Function
// RULE1: The host holds the reset input high until supplies are stable, then drives it low.
// RULE2: The host programs the timer period, pulse options and channel settings before restart.
// RULE3: Writing the divider restart bit to 1 then 0 resets dividers and state machines.
// RULE4: A phase realign request aligns all divider phases and sends any initial pulse chain; the code sends no pulse chain on a realign.
// RULE5: The host waits at least six timer periods after a sync request before using phases.
// RULE6: The host proceeds with other devices only once the output-phase status bit reads 1.
// RULE7: A pulse generator request sends a pulse chain on every pulse-mode SYSREF channel; the code gates only those with channel and sync enable set.
// RULE8: A SYSREF-valid flag is high once settings and phases are established, low otherwise.
// RULE9: The host makes receivers ignore SYSREF before clearing SYSREF channel enables.
// RULE10: The host sets channel and sync enable on channels to resync, clears sync elsewhere.
// RULE11: A channel with sync enable cleared keeps running untouched during a sync request.
// RULE12: The host waits twenty timer periods after realign before a pulse generator request.
// RULE13: Channels are grouped in fixed pairs sharing one sync retiming flip-flop.
// RULE14: The host keeps the timer period a submultiple of the lowest output, at most 4 MHz.
// RULE15: The timer sequences enable, reset, start and disable of dividers in whole periods; the code times no disable step.
// RULE16: The host issues no new request until SYSREF-valid shows the last one complete.
`default_nettype none
package ssq_pkg;
    localparam int NUM_CH     = 14;
    localparam int NUM_PAIRS  = 7;
    localparam int PER_W      = 12;
    localparam int PULSE_W    = 4;

    // Status register, read only
    localparam logic [7:0] SYNC_STATUS_FLAGS_ADDR = 8'h7d;
    localparam int         STAT_PHASE_OK_BIT      = 1;
    localparam int         STAT_VALID_BIT         = 2;
    localparam int         STAT_BUSY_BIT          = 3;
    localparam logic [7:0] STATUS_RESET           = 8'h00;

    // Timer periods spent in the settle phase and in each enable, reset and start step
    localparam logic [3:0] SETTLE_PERIODS = 4'h6;
    localparam logic [3:0] STEP_PERIODS   = 4'h1;

    typedef enum logic [7:0] {
        SSQ_IDLE    = 8'b0000_0001,
        SSQ_RESTART = 8'b0000_0010,
        SSQ_ENABLE  = 8'b0000_0100,
        SSQ_RESET   = 8'b0000_1000,
        SSQ_START   = 8'b0001_0000,
        SSQ_SETTLE  = 8'b0010_0000,
        SSQ_PULSE   = 8'b0100_0000,
        SSQ_DONE    = 8'b1000_0000
    } ssq_state_t;

    // Per-channel configuration written by the host
    typedef struct packed {
        logic [NUM_CH-1:0] chan_enable;
        logic [NUM_CH-1:0] sync_enable;
        logic [NUM_CH-1:0] pulse_mode;
    } ssq_chan_cfg_t;

    // Per-channel divider controls
    typedef struct packed {
        logic [NUM_CH-1:0] div_enable;
        logic [NUM_CH-1:0] div_reset;
        logic [NUM_CH-1:0] pulse_gate;
    } ssq_chan_ctl_t;
endpackage
`default_nettype wire

// ==== design/ssq_sequencer.sv ====
// SYSREF timer, sync and pulse generator sequencer with valid flag
`default_nettype none
module ssq_sequencer (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    srst,
    // Host control bits
    input  wire logic                    divider_restart_bit,
    input  wire logic                    phase_realign_req,
    input  wire logic                    pulse_gen_req,
    input  wire logic [ssq_pkg::PER_W-1:0]   sysref_period_count,
    input  wire logic [ssq_pkg::PULSE_W-1:0] pulse_count,
    input  wire logic                    gpo_select_valid,
    input  wire ssq_pkg::ssq_chan_cfg_t  chan_cfg,
    // Divider controls
    output ssq_pkg::ssq_chan_ctl_t       chan_ctl,
    // Status
    output logic                         sysref_valid,
    output logic                         general_output_pin,
    output logic [7:0]                   sync_status_flags
);
    import ssq_pkg::*;

    ssq_state_t        state;
    ssq_state_t        next_state;
    logic [PER_W-1:0]  tmr;
    logic [3:0]        periods;
    logic              realign_q;
    logic              pulse_q;
    logic              pulse_seq;
    logic              phase_ok;
    logic [NUM_PAIRS-1:0] pair_sync;

    // Rest states accept a new request; everything else counts as busy
    function automatic logic is_rest(input ssq_state_t s);
        return (s == SSQ_IDLE) || (s == SSQ_DONE);
    endfunction

    // Packs the status flags at their fixed bit positions, spare bits zero
    function automatic logic [7:0] status_word(
        input logic phase_good,
        input logic valid,
        input logic busy
    );
        logic [7:0] w;
        w = STATUS_RESET;
        w[STAT_PHASE_OK_BIT] = phase_good;
        w[STAT_VALID_BIT]    = valid;
        w[STAT_BUSY_BIT]     = busy;
        return w;
    endfunction

    wire logic [PER_W-1:0] per_last   = (sysref_period_count == '0) ? '0
                                      : sysref_period_count - 12'h001;
    wire logic tick         = (tmr == per_last);
    wire logic realign_rise = phase_realign_req & ~realign_q;
    wire logic pulse_rise   = pulse_gen_req & ~pulse_q;
    wire logic can_accept   = is_rest(state);
    wire logic [3:0] need   = (state == SSQ_SETTLE) ? SETTLE_PERIODS
                            : (state == SSQ_PULSE)  ? pulse_count
                            : STEP_PERIODS;
    wire logic step_done    = tick && (periods + 4'h1 >= need);
    wire logic [NUM_CH-1:0] sync_set = chan_cfg.chan_enable & chan_cfg.sync_enable;
    wire logic [NUM_CH-1:0] pulse_set = sync_set & chan_cfg.pulse_mode;

    // One retime flop per clock group, shared by both channels of the pair
    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    pair_sync[g] <= 1'b0;
                end else begin
                    pair_sync[g] <= (state == SSQ_RESET); // RULE13
                end
            end
        end
    endgenerate

    wire logic [NUM_CH-1:0] ch_sync;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign ch_sync[g] = pair_sync[g/2]; // RULE13
        end
    endgenerate

    always_comb begin
        next_state = state;
        unique case (state)
            SSQ_IDLE, SSQ_DONE: begin
                if (realign_rise) begin
                    next_state = SSQ_ENABLE; // RULE4
                end else if (pulse_rise) begin
                    next_state = SSQ_ENABLE; // RULE7
                end
            end
            SSQ_RESTART: next_state = SSQ_IDLE;
            SSQ_ENABLE:  if (step_done) next_state = SSQ_RESET; // RULE15
            SSQ_RESET:   if (step_done) next_state = SSQ_START; // RULE15
            SSQ_START:   if (step_done) next_state = pulse_seq ? SSQ_PULSE : SSQ_SETTLE;
            SSQ_PULSE:   if (step_done || pulse_count == 4'h0) next_state = SSQ_SETTLE;
            SSQ_SETTLE:  if (step_done) next_state = SSQ_DONE;
            default:     next_state = SSQ_IDLE;
        endcase
        // Restart bit overrides any sequence in flight
        if (divider_restart_bit) begin
            next_state = SSQ_RESTART; // RULE3
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state     <= SSQ_IDLE;
            realign_q <= 1'b0;
            pulse_q   <= 1'b0;
        end else begin
            state     <= next_state;
            realign_q <= phase_realign_req;
            pulse_q   <= pulse_gen_req;
        end
    end

    // Period timer restarts on every state change so phases last whole periods
    always_ff @(posedge clk_sys) begin
        if (srst || state != next_state) begin
            tmr     <= '0;
            periods <= '0;
        end else if (tick) begin
            tmr     <= '0; // RULE15
            periods <= periods + 4'h1;
        end else begin
            tmr     <= tmr + 12'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pulse_seq <= 1'b0;
        end else if (can_accept && !divider_restart_bit) begin
            pulse_seq <= ~realign_rise & pulse_rise;
        end
    end

    // Phases are good only after a full realign has settled; restart drops them
    wire logic phase_ok_set  = (state == SSQ_SETTLE) && step_done && !pulse_seq;
    wire logic next_phase_ok = divider_restart_bit ? 1'b0 : (phase_ok | phase_ok_set);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_ok <= 1'b0;
        end else begin
            phase_ok <= next_phase_ok; // RULE4
        end
    end

    // Valid lands on the same edge as DONE, so status shows next values
    wire logic valid_now  = (next_state == SSQ_DONE)
                          && (phase_ok || state == SSQ_SETTLE);
    wire logic busy_now   = ~is_rest(next_state);
    wire logic in_restart = (state == SSQ_RESTART);
    wire logic in_pulse   = (state == SSQ_PULSE);

    // Outside a restart, masked channels keep running; only synced ones are touched
    wire logic [NUM_CH-1:0] next_div_enable = in_restart ? '0 : chan_cfg.chan_enable;
    wire logic [NUM_CH-1:0] next_div_reset  = in_restart ? {NUM_CH{1'b1}}
                                            : (ch_sync & sync_set);
    wire logic [NUM_CH-1:0] next_pulse_gate = in_pulse ? pulse_set : '0;
    wire logic [7:0]        next_status     = status_word(next_phase_ok, valid_now, busy_now);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            chan_ctl.div_enable <= '0;
        end else begin
            chan_ctl.div_enable <= next_div_enable; // RULE11
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            chan_ctl.div_reset <= '0;
        end else begin
            chan_ctl.div_reset <= next_div_reset; // RULE3 RULE11
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            chan_ctl.pulse_gate <= '0;
        end else begin
            chan_ctl.pulse_gate <= next_pulse_gate; // RULE7
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sysref_valid <= 1'b0;
        end else begin
            sysref_valid <= valid_now; // RULE8
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            general_output_pin <= 1'b0;
        end else begin
            general_output_pin <= gpo_select_valid & valid_now; // RULE8
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_status_flags <= STATUS_RESET;
        end else begin
            sync_status_flags <= next_status; // RULE8
        end
    end
endmodule
`default_nettype wire

// ==== test/ssq_checker.sv ====
// Assertion checker for the SYSREF sync sequencer
`default_nettype none
module ssq_checker (
    // Clock and reset
    input wire logic                   clk_sys,
    input wire logic                   srst,
    // Host control
    input wire logic                   divider_restart_bit,
    input wire logic                   phase_realign_req,
    input wire logic                   gpo_select_valid,
    input wire ssq_pkg::ssq_chan_cfg_t chan_cfg,
    // Outputs
    input wire ssq_pkg::ssq_chan_ctl_t chan_ctl,
    input wire logic                   sysref_valid,
    input wire logic                   general_output_pin,
    input wire logic [7:0]             sync_status_flags
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire logic [13:0] sel = chan_cfg.chan_enable & chan_cfg.sync_enable;
    sequence s_req;
        $rose(phase_realign_req) && !sync_status_flags[3]
            && !divider_restart_bit && !$past(divider_restart_bit);
    endsequence
    sequence s_run_free;
        (!divider_restart_bit) [*4];
    endsequence
    a_restart_all_ones: assert property (divider_restart_bit [*3] |->
        &chan_ctl.div_reset && !sysref_valid) else $error("restart not applied");
    a_request_busy: assert property (s_req |-> ##[1:2] sync_status_flags[3])
        else $error("request not taken");
    a_realign_done: assert property (s_req |-> ##[9:1000] sysref_valid)
        else $error("valid missing after realign");
    a_busy_not_valid: assert property (sync_status_flags[3] |-> !sysref_valid)
        else $error("valid while busy");
    a_flag_mirrors: assert property (sync_status_flags[2] == sysref_valid)
        else $error("status flag differs from valid");
    a_gpo_route: assert property (general_output_pin |-> $past(gpo_select_valid))
        else $error("output pin not selected");
    a_sync_mask: assert property (s_run_free |-> (chan_ctl.div_reset & ~sel) == '0)
        else $error("masked channel reset");
    a_pulse_mask: assert property ((chan_ctl.pulse_gate & ~(sel & chan_cfg.pulse_mode)) == '0)
        else $error("pulse on wrong channel");
endmodule
bind ssq_sequencer ssq_checker u_chk (.*);
`default_nettype wire

// ==== test/ssq_rx_model.sv ====
// Receiver model counting SYSREF pulse cycles it listens to
`default_nettype none
module ssq_rx_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Sensitivity and lanes
    input  wire logic        ignore,
    input  wire logic [13:0] sysref_lane,
    output int               pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk_sys) begin
        if (srst) pulses <= 0;
        else if (!ignore && |sysref_lane) pulses <= pulses + 1;
    end
endmodule
`default_nettype wire

// ==== test/tb_ssq_sequencer.sv ====
// Self-checking bench for the SYSREF sync sequencer
`default_nettype none
module tb_ssq_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import ssq_pkg::*;
    logic clk_sys = 0, srst = 1, divider_restart_bit = 1, ignore = 1;
    logic phase_realign_req = 0, pulse_gen_req = 0, gpo_select_valid = 0;
    logic [PER_W-1:0] sysref_period_count = 12'h003;
    logic [PULSE_W-1:0] pulse_count = 4'h1;
    ssq_chan_cfg_t chan_cfg = '0;
    ssq_chan_ctl_t chan_ctl;
    logic sysref_valid, general_output_pin;
    logic [7:0] sync_status_flags;
    logic [13:0] rs, pg, sel;
    int fails = 0, comparisons = 0, cyc = 0, pulses, n, p, p0;
    ssq_sequencer uut (.*);
    ssq_rx_model rx (.clk_sys, .srst, .ignore, .sysref_lane(chan_ctl.pulse_gate), .pulses);
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (++cyc == 3000) begin fails++; close_out(); end
    task automatic chk(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // Request, then wait for valid while collecting what the lanes did
    task automatic run(input logic pulse, input int len);
        rs = '0; pg = '0; n = 0;
        @(posedge clk_sys);
        phase_realign_req <= !pulse;
        pulse_gen_req <= pulse;
        do begin
            @(posedge clk_sys);
            phase_realign_req <= 1'b0;
            pulse_gen_req <= 1'b0;
            #1;
            rs |= chan_ctl.div_reset;
            pg |= chan_ctl.pulse_gate;
            n++;
        end while (sysref_valid !== 1'b1 || n < 3);
        chk(n >= len && n <= len + 2, 1, "sequence length");
        chk(sync_status_flags, 8'h06, "status");
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h6c83));
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(chan_ctl.div_reset, 14'h3fff, "restart lanes");
        repeat (3) begin
            @(posedge clk_sys);
            divider_restart_bit <= 1'b0;
            chan_cfg <= ssq_chan_cfg_t'(42'({$urandom, $urandom}));
            sysref_period_count <= 12'($urandom_range(4, 1));
            pulse_count <= 4'($urandom_range(3, 1));
            gpo_select_valid <= 1'($urandom);
            repeat (3) @(posedge clk_sys);
            p = sysref_period_count;
            sel = chan_cfg.chan_enable & chan_cfg.sync_enable;
            run(1'b0, 9 * p);
            chk(rs, sel, "sync lanes");
            chk(general_output_pin, gpo_select_valid, "output pin");
            ignore <= 1'b0;
            repeat (20 * p) @(posedge clk_sys);
            p0 = pulses;
            run(1'b1, (9 + pulse_count) * p);
            chk(pg, sel & chan_cfg.pulse_mode, "pulse lanes");
            chk(pulses - p0, (sel & chan_cfg.pulse_mode) != 0 ? pulse_count * p : 0, "pulse cycles");
            ignore <= 1'b1;
        end
        close_out();
    end
endmodule
`default_nettype wire
